// ---- rtl/iig_pkg.sv ----
// package: constants for the interrupt instruction group
package iig_pkg;
  // ***********************************************
  // opcode encodings
  // ***********************************************
  localparam logic [9:0] IIG_OP_MASK       = 10'h004;
  localparam logic [9:0] IIG_OP_UNMASK     = 10'h005;
  localparam logic [9:0] IIG_OP_SKIP_REQ   = 10'h038;
  localparam logic [9:0] IIG_OP_SKIP_PIN   = 10'h03A;
  localparam logic [9:0] IIG_OP_RD_FIRST   = 10'h054;
  localparam logic [9:0] IIG_OP_WR_FIRST   = 10'h03F;
  localparam logic [9:0] IIG_OP_RD_SECOND  = 10'h055;
  localparam logic [9:0] IIG_OP_WR_SECOND  = 10'h03E;
  localparam logic [9:0] IIG_OP_RD_PIN     = 10'h253;
  localparam logic [9:0] IIG_OP_WR_PIN     = 10'h217;
  // ***********************************************
  // field positions and reset values
  // ***********************************************
  localparam int         IIG_GUARD_BIT     = 0;
  localparam int         IIG_LEVEL_SEL_BIT = 2;
  localparam logic [3:0] IIG_CTL_RST       = 4'h0;
  localparam logic       IIG_MIE_RST       = 1'b0;
  // ***********************************************
  // decoded operation classes
  // ***********************************************
  typedef enum logic [3:0] {
    IIG_NONE, IIG_MASK, IIG_UNMASK, IIG_SKIP_REQ, IIG_SKIP_PIN,
    IIG_RD_FIRST, IIG_WR_FIRST, IIG_RD_SECOND, IIG_WR_SECOND,
    IIG_RD_PIN, IIG_WR_PIN
  } iig_op_t;
endpackage

// ---- rtl/iig_dec_if.sv ----
// interface: decoded operation from decoder to executor
`timescale 1ns/1ns
`default_nettype none
interface iig_dec_if;
  import iig_pkg::*;
  iig_op_t op;
  modport dec (output op);
  modport exe (input op);
endinterface
`default_nettype wire

// ---- rtl/iig_decoder.sv ----
// module: opcode decoder for the interrupt instruction group
`timescale 1ns/1ns
`default_nettype none
module iig_decoder
  import iig_pkg::*;
(
  input  wire logic [9:0] opcode_i,
  iig_dec_if.dec          dec
);
  // ***********************************************
  // pure decode, combinational
  // ***********************************************
  always_comb begin
    case (opcode_i)
      IIG_OP_MASK:      dec.op = IIG_MASK;
      IIG_OP_UNMASK:    dec.op = IIG_UNMASK;
      IIG_OP_SKIP_REQ:  dec.op = IIG_SKIP_REQ;
      IIG_OP_SKIP_PIN:  dec.op = IIG_SKIP_PIN;
      IIG_OP_RD_FIRST:  dec.op = IIG_RD_FIRST;
      IIG_OP_WR_FIRST:  dec.op = IIG_WR_FIRST;
      IIG_OP_RD_SECOND: dec.op = IIG_RD_SECOND;
      IIG_OP_WR_SECOND: dec.op = IIG_WR_SECOND;
      IIG_OP_RD_PIN:    dec.op = IIG_RD_PIN;
      IIG_OP_WR_PIN:    dec.op = IIG_WR_PIN;
      default:          dec.op = IIG_NONE;
    endcase
  end
endmodule
`default_nettype wire

// ---- rtl/iig_core.sv ----
// module: execution of the interrupt instruction group
`timescale 1ns/1ns
`default_nettype none
module iig_core
  import iig_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       instr_valid_i,
  input  wire logic [9:0] opcode_i,
  input  wire logic [3:0] acc_i,
  input  wire logic       ext0_set_i,
  input  wire logic       int_pin_i,
  output logic            master_irq_enable_o,
  output logic            ext0_request_flag_o,
  output logic [3:0]      irq_ctl_first_o,
  output logic [3:0]      irq_ctl_second_o,
  output logic [3:0]      pin_irq_ctl_o,
  output logic [3:0]      acc_o,
  output logic            acc_we_o,
  output logic            skip_o
);
  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic       mie;
    logic       ext0;
    logic [3:0] ctl1;
    logic [3:0] ctl2;
    logic [3:0] pctl;
    logic [3:0] acc;
    logic       acc_we;
    logic       skip;      // next instruction is suppressed
    logic [2:0] pin_sync;  // three-stage pin synchroniser
    logic       pin_lvl;   // filtered pin level, moves on agreement only
  } iig_state_t;

  iig_state_t st;
  iig_state_t next_st;
  iig_dec_if  dec_bus ();
  logic       pin_lvl;
  logic       exec;

  iig_decoder u_dec (
    .opcode_i (opcode_i),
    .dec      (dec_bus)
  );

  // filtered level lives in the state; a glitch that reaches only the
  // second stage never disturbs a pending pin skip test
  assign pin_lvl = st.pin_lvl;
  // a skipped slot is fetched but never executed
  assign exec = instr_valid_i && !st.skip;

  // ***********************************************
  // next-state logic
  // ***********************************************
  always_comb begin
    next_st          = st;
    next_st.acc_we   = 1'b0;
    next_st.pin_sync = {st.pin_sync[1:0], int_pin_i};
    // the level moves only once stages two and three agree
    if (st.pin_sync[1] == st.pin_sync[2]) begin
      next_st.pin_lvl = st.pin_sync[2];
    end
    if (instr_valid_i) begin
      next_st.skip = 1'b0; // the suppressed slot consumes the skip
    end
    if (exec) begin
      case (dec_bus.op)
        IIG_MASK:   next_st.mie = 1'b0;
        IIG_UNMASK: next_st.mie = 1'b1;
        IIG_SKIP_REQ: begin
          // guard set makes this a no-op
          if (!st.ctl1[IIG_GUARD_BIT] && st.ext0) begin
            next_st.ext0 = 1'b0;
            next_st.skip = 1'b1;
          end // else falls through, no skip
        end
        IIG_SKIP_PIN: begin
          if (st.pctl[IIG_LEVEL_SEL_BIT]) begin
            next_st.skip = pin_lvl;
          end else begin
            next_st.skip = !pin_lvl;
          end
        end
        IIG_RD_FIRST: begin
          next_st.acc    = st.ctl1;
          next_st.acc_we = 1'b1;
        end
        IIG_WR_FIRST: next_st.ctl1 = acc_i;
        IIG_RD_SECOND: begin
          next_st.acc    = st.ctl2;
          next_st.acc_we = 1'b1;
        end
        IIG_WR_SECOND: next_st.ctl2 = acc_i;
        IIG_RD_PIN: begin
          next_st.acc    = st.pctl;
          next_st.acc_we = 1'b1;
        end
        IIG_WR_PIN: next_st.pctl = acc_i;
        default: ;
      endcase
    end
    // a new request wins over a clear in the same cycle
    if (ext0_set_i) begin
      next_st.ext0 = 1'b1;
    end
  end

  // ***********************************************
  // registers, frozen while the clock enable is low and reset is not asserted
  // ***********************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '{mie: IIG_MIE_RST, ext0: 1'b0, ctl1: IIG_CTL_RST, ctl2: IIG_CTL_RST,
              pctl: IIG_CTL_RST, acc: 4'h0, acc_we: 1'b0, skip: 1'b0,
              pin_sync: 3'h0, pin_lvl: 1'b0};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign master_irq_enable_o = st.mie;
  assign ext0_request_flag_o = st.ext0;
  assign irq_ctl_first_o     = st.ctl1;
  assign irq_ctl_second_o    = st.ctl2;
  assign pin_irq_ctl_o       = st.pctl;
  assign acc_o               = st.acc;
  assign acc_we_o            = st.acc_we;
  assign skip_o              = st.skip;

  // ***********************************************
  // assertions
  // ***********************************************
  // properties watch the registered outputs one edge after the slot
  sequence s_exec_op(logic [9:0] op);
    ce_i && exec && opcode_i == op;
  endsequence

  // a slot that arrives while the skip is pending
  sequence s_skip_armed;
    ce_i && instr_valid_i && skip_o;
  endsequence

  // request skip test that finds the flag set with the guard clear
  sequence s_req_hit;
    s_exec_op(IIG_OP_SKIP_REQ) ##0 (!irq_ctl_first_o[IIG_GUARD_BIT] && ext0_request_flag_o);
  endsequence

  property p_mask;
    @(posedge clk_i) disable iff (srst_i) s_exec_op(IIG_OP_MASK) |=> !master_irq_enable_o;
  endproperty
  a_mask: assert property (p_mask) else $error("mask op left enable set");

  property p_unmask;
    @(posedge clk_i) disable iff (srst_i) s_exec_op(IIG_OP_UNMASK) |=> master_irq_enable_o;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask op left enable clear");

  property p_req_skip;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_SKIP_REQ) ##0 (!irq_ctl_first_o[0] && ext0_request_flag_o && !ext0_set_i)
      |=> skip_o && !ext0_request_flag_o;
  endproperty
  a_req_skip: assert property (p_req_skip) else $error("request skip not taken");

  property p_req_noskip;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_SKIP_REQ) ##0 !ext0_request_flag_o |=> !skip_o;
  endproperty
  a_req_noskip: assert property (p_req_noskip) else $error("skip without request");

  property p_req_nop;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_SKIP_REQ) ##0 (irq_ctl_first_o[0] && !ext0_set_i)
      |=> !skip_o && ext0_request_flag_o == $past(ext0_request_flag_o);
  endproperty
  a_req_nop: assert property (p_req_nop) else $error("guarded op not a no-op");

  property p_pin_skip;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_SKIP_PIN) |=> skip_o == ($past(pin_irq_ctl_o[2]) ~^ $past(pin_lvl));
  endproperty
  a_pin_skip: assert property (p_pin_skip) else $error("pin skip wrong");

  property p_rd_first;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_RD_FIRST) |=> acc_we_o && acc_o == $past(irq_ctl_first_o);
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("first read wrong");

  property p_wr_pin;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_WR_PIN) |=> pin_irq_ctl_o == $past(acc_i);
  endproperty
  a_wr_pin: assert property (p_wr_pin) else $error("pin write wrong");

  property p_suppress;
    @(posedge clk_i) disable iff (srst_i)
      s_skip_armed |=> !acc_we_o && $stable(irq_ctl_first_o)
      && $stable(irq_ctl_second_o) && $stable(pin_irq_ctl_o)
      && $stable(master_irq_enable_o);
  endproperty
  a_suppress: assert property (p_suppress) else $error("skipped op took effect");

  // the swallowed slot uses up the skip, so only one slot is lost
  property p_skip_consumed;
    @(posedge clk_i) disable iff (srst_i) s_skip_armed |=> !skip_o;
  endproperty
  a_skip_consumed: assert property (p_skip_consumed) else $error("skip outlived its slot");

  // full request walk: hit, swallowed slot, skip gone
  property p_req_walk;
    @(posedge clk_i) disable iff (srst_i)
      s_req_hit ##1 s_skip_armed |=> !skip_o && !acc_we_o;
  endproperty
  a_req_walk: assert property (p_req_walk) else $error("request skip walk broken");

  property p_wr_first;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_WR_FIRST) |=> irq_ctl_first_o == $past(acc_i);
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("first write wrong");

  property p_rd_second;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_RD_SECOND) |=> acc_we_o && acc_o == $past(irq_ctl_second_o);
  endproperty
  a_rd_second: assert property (p_rd_second) else $error("second read wrong");

  property p_wr_second;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_WR_SECOND) |=> irq_ctl_second_o == $past(acc_i);
  endproperty
  a_wr_second: assert property (p_wr_second) else $error("second write wrong");

  property p_rd_pin;
    @(posedge clk_i) disable iff (srst_i)
      s_exec_op(IIG_OP_RD_PIN) |=> acc_we_o && acc_o == $past(pin_irq_ctl_o);
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("pin read wrong");

  // writes load a register only, they never strobe the accumulator
  property p_wr_no_strobe;
    @(posedge clk_i) disable iff (srst_i)
      (ce_i && exec && (dec_bus.op == IIG_WR_FIRST || dec_bus.op == IIG_WR_SECOND
      || dec_bus.op == IIG_WR_PIN)) |=> !acc_we_o;
  endproperty
  a_wr_no_strobe: assert property (p_wr_no_strobe) else $error("write raised strobe");

  // clock enable low holds every register, synchroniser included
  property p_freeze;
    @(posedge clk_i) disable iff (srst_i)
      !ce_i |=> $stable(master_irq_enable_o) && $stable(ext0_request_flag_o)
      && $stable(irq_ctl_first_o) && $stable(irq_ctl_second_o)
      && $stable(pin_irq_ctl_o) && $stable(acc_o) && $stable(acc_we_o)
      && $stable(skip_o) && $stable(pin_lvl);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // a request event is never lost to a clear in the same cycle
  property p_set_wins;
    @(posedge clk_i) disable iff (srst_i) (ce_i && ext0_set_i) |=> ext0_request_flag_o;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("request event lost");

  // the write strobe is a single pulse unless another read follows
  property p_we_pulse;
    @(posedge clk_i) disable iff (srst_i) (ce_i && acc_we_o && !exec) |=> !acc_we_o;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe stuck");

  // opcodes outside the group raise no skip or strobe and leave the enable and control registers alone
  property p_foreign_op;
    @(posedge clk_i) disable iff (srst_i)
      (ce_i && exec && dec_bus.op == IIG_NONE) |=> !skip_o && !acc_we_o
      && $stable(master_irq_enable_o) && $stable(irq_ctl_first_o)
      && $stable(irq_ctl_second_o) && $stable(pin_irq_ctl_o);
  endproperty
  a_foreign_op: assert property (p_foreign_op) else $error("foreign opcode had effect");

  // a level seen by only one synchroniser stage is not yet believed
  property p_pin_filter;
    @(posedge clk_i) disable iff (srst_i)
      (ce_i && st.pin_sync[1] != st.pin_sync[2]) |=> $stable(pin_lvl);
  endproperty
  a_pin_filter: assert property (p_pin_filter) else $error("pin level moved early");

  // two agreeing stages hand their level on at the next edge
  property p_pin_follow;
    @(posedge clk_i) disable iff (srst_i)
      (ce_i && st.pin_sync[1] == st.pin_sync[2]) |=> pin_lvl == $past(st.pin_sync[2]);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin level did not follow");

  // reset clears every register at the next edge, enable or not
  property p_reset_values;
    @(posedge clk_i)
      srst_i |=> master_irq_enable_o == IIG_MIE_RST && !ext0_request_flag_o
      && !acc_we_o && !skip_o && irq_ctl_first_o == IIG_CTL_RST
      && irq_ctl_second_o == IIG_CTL_RST && pin_irq_ctl_o == IIG_CTL_RST;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
endmodule
`default_nettype wire

// ---- verification/test_interrupt_instruction_group.sv ----
// testbench: random and corner instruction streams for the interrupt group
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_instruction_group
  import iig_pkg::*;
;
  typedef struct packed {
    logic       mie, flag, skip, we;
    logic [3:0] c1, c2, pin, acc;
  } iig_exp_t;
  localparam logic [9:0] OPS [10] = '{IIG_OP_MASK, IIG_OP_UNMASK, IIG_OP_SKIP_REQ,
    IIG_OP_SKIP_PIN, IIG_OP_RD_FIRST, IIG_OP_WR_FIRST, IIG_OP_RD_SECOND,
    IIG_OP_WR_SECOND, IIG_OP_RD_PIN, IIG_OP_WR_PIN};
  logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, instr_valid_i = 1'b0;
  logic ext0_set_i = 1'b0, int_pin_i = 1'b0;
  logic [9:0] opcode_i = 10'h000;
  logic [3:0] acc_i = 4'h0, c1, c2, pc, acc_o;
  logic mie, flag, we, skip;
  int errors = 0, check_count = 0, cycles = 0;
  logic [31:0] seed = 32'h523F;
  iig_exp_t exp_s = '0;
  iig_core dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .acc_i(acc_i), .ext0_set_i(ext0_set_i), .int_pin_i(int_pin_i),
    .master_irq_enable_o(mie), .ext0_request_flag_o(flag), .irq_ctl_first_o(c1),
    .irq_ctl_second_o(c2), .pin_irq_ctl_o(pc), .acc_o(acc_o), .acc_we_o(we), .skip_o(skip));
  always #10 clk_i = ~clk_i;
  // ***********************************************
  // expectation and checking
  // ***********************************************
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // a suppressed slot only clears the skip; a set event always wins
  function automatic iig_exp_t predict(iig_exp_t s, logic [9:0] op, logic [3:0] a,
                                       logic pin, logic set);
    iig_exp_t n;
    n = s;
    n.we = 1'b0;
    n.skip = 1'b0;
    if (!s.skip) begin
      case (op)
        IIG_OP_MASK: n.mie = 1'b0;
        IIG_OP_UNMASK: n.mie = 1'b1;
        IIG_OP_SKIP_REQ: if (!s.c1[IIG_GUARD_BIT] && s.flag) begin
          n.skip = 1'b1;
          n.flag = 1'b0;
        end
        IIG_OP_SKIP_PIN: n.skip = (pin == s.pin[IIG_LEVEL_SEL_BIT]);
        IIG_OP_RD_FIRST: {n.we, n.acc} = {1'b1, s.c1};
        IIG_OP_RD_SECOND: {n.we, n.acc} = {1'b1, s.c2};
        IIG_OP_RD_PIN: {n.we, n.acc} = {1'b1, s.pin};
        IIG_OP_WR_FIRST: n.c1 = a;
        IIG_OP_WR_SECOND: n.c2 = a;
        IIG_OP_WR_PIN: n.pin = a;
        default: n.we = 1'b0;
      endcase
    end
    if (set) n.flag = 1'b1;
    return n;
  endfunction
  task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic check_all();
    check("mie", {3'b0, mie}, {3'b0, exp_s.mie}); // enable state
    check("flag", {3'b0, flag}, {3'b0, exp_s.flag}); // request flag
    check("skip", {3'b0, skip}, {3'b0, exp_s.skip}); // skip
    check("ctl1", c1, exp_s.c1); // first control
    check("ctl2", c2, exp_s.c2); // second control
    check("pinctl", pc, exp_s.pin); // pin control
    check("acc_we", {3'b0, we}, {3'b0, exp_s.we}); // acc write
    if (exp_s.we) check("acc", acc_o, exp_s.acc); // read data
  endtask
  // ***********************************************
  // drivers
  // ***********************************************
  // one slot then one idle cycle, checked once the edge has landed
  task automatic step(logic ce, logic [9:0] op, logic [3:0] a, logic set);
    @(posedge clk_i);
    ce_i <= ce;
    instr_valid_i <= 1'b1;
    opcode_i <= op;
    acc_i <= a;
    ext0_set_i <= set;
    @(posedge clk_i);
    ce_i <= 1'b1;
    instr_valid_i <= 1'b0;
    ext0_set_i <= 1'b0;
    // the idle edge before a frozen slot still ends the write strobe
    if (ce) exp_s = predict(exp_s, op, a, int_pin_i, set);
    else exp_s.we = 1'b0;
    #1;
    check_all();
  endtask
  // pin passes a synchroniser, so give it settling time before use
  task automatic set_pin(logic v);
    @(posedge clk_i);
    int_pin_i <= v;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    exp_s = '0;
    #1;
    check_all();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    logic [9:0] op;
    do_reset();
    step(1'b1, IIG_OP_WR_FIRST, 4'h0, 1'b0);
    step(1'b1, IIG_OP_SKIP_REQ, 4'h0, 1'b1);
    step(1'b1, IIG_OP_SKIP_REQ, 4'h0, 1'b0);
    step(1'b1, IIG_OP_WR_PIN, 4'hF, 1'b0);
    step(1'b1, IIG_OP_WR_FIRST, 4'h1, 1'b1);
    step(1'b1, IIG_OP_SKIP_REQ, 4'h0, 1'b0);
    $display("test corner done");
    repeat (500) begin
      seed = xs(seed);
      if (seed[31:29] == 3'h0) set_pin(seed[28]);
      op = (seed[3:0] > 4'h9) ? seed[25:16] : OPS[seed[3:0]];
      step(seed[7:5] != 3'h0, op, seed[11:8], seed[14:12] == 3'h0);
    end
    $display("test random done");
    do_reset();
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire
